// *** src/cac_array.sv ***
// counter array with six capture/compare channels behind an ahb-lite slave
`timescale 1ns/1ps
`include "cac_defs.svh"

// Notes on behaviour
// - capture edge copies counter, sets channel flag
// - rise/fall enables pick edge, both any
// - flag plus enable raises irq; software clears
// - timer mode flags on full 16-bit match
// - low write clears comparator, high sets
// - high-speed match toggles pin, sets flag
// - comparator off keeps high-speed pin level
// - frequency mode toggles, adds high to low
// - half period is high byte, zero 256
// - frequency mode decoded from mode bits
// - frequency mode flags on 16-bit match
// - n-bit pwm channels share cycle length
// - 8-bit pwm sets on match, clears overflow
// - 8-bit pwm reloads low from high
// - cycle length zero means 8-bit pwm
// - reload select steers compare byte access
// - n-bit pwm match high, overflow low reload
// - 16-bit pwm match high, wrap low
// - pwm with comparator off holds pin low
// - wrap flag sets on 16-bit rollover
// - overflow flag on bit 8..11 carry
module cac_array (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // counter timebase tick, one cycle per counter clock
  input  wire logic        count_tick,
  // channel pins
  input  wire logic [5:0]  module_io_pin_in,
  output logic      [5:0]  module_io_pin_out,
  output logic      [5:0]  module_io_pin_oe_n,
  // interrupt request
  output logic             counter_array_irq
);

  // -----------------------------------------------------------------------
  // state
  // -----------------------------------------------------------------------
  cac_pkg::cac_chan_t ch [`CAC_NCH];
  logic [15:0] count;
  logic [7:0]  array_control_register;
  logic [7:0]  pwm_config_register;
  logic [5:0]  module_event_flag;
  logic        counter_wrap_flag;
  logic        intermediate_overflow_flag;
  logic [5:0]  pin_s1, pin_s2, pin_d;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic [31:0] next_rdata;

  // one channel's operating mode, decoded from its mode byte alone
  function automatic cac_pkg::cac_mode_t mode_of(input logic [7:0] m);
    if (m[`CAC_M_RISE] | m[`CAC_M_FALL])
      mode_of = cac_pkg::CAC_CAPTURE;
    else if (m[`CAC_M_PULSE] & m[`CAC_M_TOG])
      mode_of = cac_pkg::CAC_FREQ;
    else if (m[`CAC_M_PULSE] & m[`CAC_M_WIDE])
      mode_of = cac_pkg::CAC_PWM16;
    else if (m[`CAC_M_PULSE])
      mode_of = cac_pkg::CAC_PWM_N;
    else if (m[`CAC_M_TOG])
      mode_of = cac_pkg::CAC_HSO;
    else if (m[`CAC_M_MAT])
      mode_of = cac_pkg::CAC_TIMER;
    else
      mode_of = cac_pkg::CAC_IDLE;
  endfunction

  // -----------------------------------------------------------------------
  // counter and its overflow events
  // -----------------------------------------------------------------------
  logic [1:0]  cycle_length_select;
  logic [10:0] nmask;
  logic        run, wrap_ev, ovf_ev, low_ovf;
  logic [15:0] cnt_next;
  assign cycle_length_select    = pwm_config_register[1:0];
  assign nmask    = 11'((12'h100 << cycle_length_select) - 12'h001);
  assign run      = array_control_register[`CAC_C_RUN] & count_tick;
  assign cnt_next = count + 16'h0001;
  assign wrap_ev  = run & (count == 16'hFFFF);
  assign low_ovf  = run & (count[7:0] == 8'hFF);
  assign ovf_ev   = run & ((count[10:0] & nmask) == nmask);

  // free-running counter; software may also load it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= `CAC_RST_WORD;
    end else if (wr_pend && wr_addr == `CAC_OFF_CNT) begin
      count <= hwdata[15:0];
    end else if (run) begin
      count <= cnt_next;
    end
  end

  // -----------------------------------------------------------------------
  // ahb-lite: one wait-free data phase, always okay
  // -----------------------------------------------------------------------
  logic take;
  assign take = hsel & hready & htrans[1];

  // read data is registered in the address phase; writes land in the data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_addr   <= `CAC_RST_BYTE;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend <= take & hwrite;
      wr_addr <= haddr;
      hrdata  <= (take & ~hwrite) ? next_rdata : 32'h0000_0000;
    end
  end

  // read mux; compare bytes follow the reload select
  always_comb begin
    logic [15:0] v;
    v = 16'h0000;
    next_rdata = 32'h0000_0000;
    case (haddr)
      `CAC_OFF_CTRL:   next_rdata = {24'h0, array_control_register};
      `CAC_OFF_FLAGS:  next_rdata = {24'h0, intermediate_overflow_flag,
                                     counter_wrap_flag, module_event_flag};
      `CAC_OFF_PWMCFG: next_rdata = {24'h0, pwm_config_register};
      `CAC_OFF_CNT:    next_rdata = {16'h0, count};
      default: begin
        for (int i = 0; i < `CAC_NCH; i++) begin
          v = pwm_config_register[`CAC_P_RELOAD_ACCESS_SELECT] ?
              {5'h00, ch[i].reload} : ch[i].cmp;
          if (haddr == 8'(`CAC_OFF_MODE0 + 4 * i))
            next_rdata = {24'h0, ch[i].mode};
          if (haddr == 8'(`CAC_OFF_CMPL0 + 4 * i))
            next_rdata = {24'h0, v[7:0]};
          if (haddr == 8'(`CAC_OFF_CMPH0 + 4 * i))
            next_rdata = {24'h0, v[15:8]};
        end
      end
    endcase
  end

  // control and pwm configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      array_control_register <= `CAC_RST_BYTE;
      pwm_config_register    <= `CAC_RST_BYTE;
    end else if (wr_pend) begin
      if (wr_addr == `CAC_OFF_CTRL)
        array_control_register <= hwdata[7:0];
      if (wr_addr == `CAC_OFF_PWMCFG)
        pwm_config_register <= hwdata[7:0];
    end
  end

  // -----------------------------------------------------------------------
  // pin synchroniser; edge detection compares the second stage with its delayed copy
  // -----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1 <= 6'h00;
      pin_s2 <= 6'h00;
      pin_d  <= 6'h00;
    end else begin
      pin_s1 <= module_io_pin_in;
      pin_s2 <= pin_s1;
      pin_d  <= pin_s2;
    end
  end

  // -----------------------------------------------------------------------
  // channels
  // -----------------------------------------------------------------------
  logic [5:0] ch_hit;
  logic [5:0] next_pin_out;

  for (genvar g = 0; g < `CAC_NCH; g++) begin : g_ch
    cac_pkg::cac_mode_t md;
    logic rise, fall, cap, m16, m8, mn, wl, wh;
    logic [7:0] mb;
    assign mb   = ch[g].mode;
    assign md   = mode_of(mb);
    assign rise = pin_s2[g] & ~pin_d[g];
    assign fall = ~pin_s2[g] & pin_d[g];
    assign cap  = md == cac_pkg::CAC_CAPTURE &&
                  ((rise & mb[`CAC_M_RISE]) |
                   (fall & mb[`CAC_M_FALL]));
    // matches look at the value the counter is about to take, so a pin
    // that follows a match is high for exactly the counts at or above the
    // compare value; a compare of zero then gives a steady high pwm level
    assign m16  = run & mb[`CAC_M_ECOM] & (cnt_next == ch[g].cmp);
    assign m8   = run & mb[`CAC_M_ECOM] &
                  (cnt_next[7:0] == ch[g].cmp[7:0]);
    assign mn   = run & mb[`CAC_M_ECOM] &
                  ((cnt_next[10:0] & nmask) == (ch[g].cmp[10:0] & nmask));
    assign wl   = wr_pend && wr_addr == 8'(`CAC_OFF_CMPL0 + 4 * g);
    assign wh   = wr_pend && wr_addr == 8'(`CAC_OFF_CMPH0 + 4 * g);

    // event that sets this channel's flag
    always_comb begin
      case (md)
        cac_pkg::CAC_CAPTURE: ch_hit[g] = cap;
        cac_pkg::CAC_TIMER,
        cac_pkg::CAC_HSO,
        cac_pkg::CAC_FREQ,
        cac_pkg::CAC_PWM16:
          ch_hit[g] = m16 & mb[`CAC_M_MAT];
        cac_pkg::CAC_PWM_N:
          ch_hit[g] = (cycle_length_select == 2'b00 ? m8 : mn) &
                      mb[`CAC_M_MAT];
        default: ch_hit[g] = 1'b0;
      endcase
    end

    // pin level for the next cycle
    always_comb begin
      next_pin_out[g] = module_io_pin_out[g];
      case (md)
        cac_pkg::CAC_HSO:
          if (m16) next_pin_out[g] = ~module_io_pin_out[g];
        cac_pkg::CAC_FREQ:
          if (m8) next_pin_out[g] = ~module_io_pin_out[g];
        cac_pkg::CAC_PWM_N:
          // a match on the overflow count wins, giving full duty at zero
          if (!mb[`CAC_M_ECOM])
            next_pin_out[g] = 1'b0;
          else if (cycle_length_select == 2'b00 ? m8 : mn)
            next_pin_out[g] = 1'b1;
          else if (cycle_length_select == 2'b00 ? low_ovf : ovf_ev)
            next_pin_out[g] = 1'b0;
        cac_pkg::CAC_PWM16:
          if (!mb[`CAC_M_ECOM]) next_pin_out[g] = 1'b0;
          else if (m16) next_pin_out[g] = 1'b1;
          else if (wrap_ev) next_pin_out[g] = 1'b0;
        default: ;
      endcase
    end

    // channel registers; hardware updates yield to a software write
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        ch[g] <= '0;
      end else begin
        if (wr_pend && wr_addr == 8'(`CAC_OFF_MODE0 + 4 * g))
          ch[g].mode <= hwdata[7:0];
        if (cap)
          ch[g].cmp <= count;
        else if (md == cac_pkg::CAC_FREQ && m8)
          ch[g].cmp[7:0] <= ch[g].cmp[7:0] + ch[g].cmp[15:8];
        else if (md == cac_pkg::CAC_PWM_N && cycle_length_select == 2'b00 && low_ovf)
          ch[g].cmp[7:0] <= ch[g].cmp[15:8];
        else if (md == cac_pkg::CAC_PWM_N && cycle_length_select != 2'b00 && ovf_ev)
          ch[g].cmp[10:0] <= ch[g].reload;
        if (wl) begin
          ch[g].mode[`CAC_M_ECOM] <= 1'b0;
          if (pwm_config_register[`CAC_P_RELOAD_ACCESS_SELECT])
            ch[g].reload[7:0] <= hwdata[7:0];
          else
            ch[g].cmp[7:0] <= hwdata[7:0];
        end
        if (wh) begin
          ch[g].mode[`CAC_M_ECOM] <= 1'b1;
          if (pwm_config_register[`CAC_P_RELOAD_ACCESS_SELECT])
            ch[g].reload[10:8] <= hwdata[2:0];
          else
            ch[g].cmp[15:8] <= hwdata[7:0];
        end
      end
    end
  end

  // -----------------------------------------------------------------------
  // flags: a set in the same cycle as a clear wins
  // -----------------------------------------------------------------------
  // software writes replace the flag byte; hardware sets are or-ed in
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      module_event_flag          <= 6'h00;
      counter_wrap_flag          <= 1'b0;
      intermediate_overflow_flag <= 1'b0;
    end else begin
      if (wr_pend && wr_addr == `CAC_OFF_FLAGS) begin
        module_event_flag          <= hwdata[5:0];
        counter_wrap_flag          <= hwdata[`CAC_F_WRAP];
        intermediate_overflow_flag <= hwdata[`CAC_F_OVF];
      end
      // a hit merges with what the write leaves, so a clear in the same
      // cycle drops the old flags but never the new event
      if (|ch_hit)
        module_event_flag <= ch_hit |
          ((wr_pend && wr_addr == `CAC_OFF_FLAGS) ?
           hwdata[5:0] : module_event_flag);
      if (wrap_ev) counter_wrap_flag <= 1'b1;
      if (ovf_ev) intermediate_overflow_flag <= 1'b1;
    end
  end

  // -----------------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------------
  // per-channel interrupt enables
  logic [5:0] ie;
  for (genvar k = 0; k < `CAC_NCH; k++) begin : g_ie
    assign ie[k] = ch[k].mode[`CAC_M_IRQ];
  end

  // pins are driven unless a channel captures or is idle; irq lags its flag one clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      module_io_pin_out  <= 6'h00;
      module_io_pin_oe_n <= 6'h3F;
      counter_array_irq  <= 1'b0;
    end else begin
      module_io_pin_out <= next_pin_out;
      for (int j = 0; j < `CAC_NCH; j++)
        module_io_pin_oe_n[j] <= mode_of(ch[j].mode) ==
                                 cac_pkg::CAC_CAPTURE ||
                                 mode_of(ch[j].mode) == cac_pkg::CAC_IDLE;
      counter_array_irq <= |(module_event_flag & ie) |
        (counter_wrap_flag & array_control_register[`CAC_C_WRAP_IE]) |
        (intermediate_overflow_flag &
         pwm_config_register[`CAC_P_OVF_IE]);
    end
  end

endmodule

// *** shared/cac_defs.svh ***
// register offsets, field positions and reset values for the capture/compare array
`ifndef CAC_DEFS_SVH
`define CAC_DEFS_SVH

// -------------------------------------------------------------------------
// register map (byte addresses, one word each)
// -------------------------------------------------------------------------
`define CAC_NCH          6
`define CAC_OFF_CTRL     8'h00
`define CAC_OFF_FLAGS    8'h04
`define CAC_OFF_PWMCFG   8'h08
`define CAC_OFF_CNT      8'h0C
`define CAC_OFF_MODE0    8'h10
`define CAC_OFF_CMPL0    8'h28
`define CAC_OFF_CMPH0    8'h40
`define CAC_OFF_LAST     8'h54

// -------------------------------------------------------------------------
// mode register fields
// -------------------------------------------------------------------------
`define CAC_M_IRQ        0
`define CAC_M_PULSE      1
`define CAC_M_TOG        2
`define CAC_M_MAT        3
`define CAC_M_FALL       4
`define CAC_M_RISE       5
`define CAC_M_ECOM       6
`define CAC_M_WIDE       7

// -------------------------------------------------------------------------
// control, flag and pwm config fields
// -------------------------------------------------------------------------
`define CAC_C_RUN        0
`define CAC_C_WRAP_IE    1
`define CAC_F_WRAP       6
`define CAC_F_OVF        7
`define CAC_P_OVF_IE     5
`define CAC_P_RELOAD_ACCESS_SELECT      7

`define CAC_RST_BYTE     8'h00
`define CAC_RST_WORD     16'h0000
`endif

// *** shared/cac_pkg.sv ***
// types shared by the capture/compare array
package cac_pkg;
  typedef enum logic [2:0] {
    CAC_CAPTURE, CAC_TIMER, CAC_HSO, CAC_FREQ, CAC_PWM_N, CAC_PWM16,
    CAC_IDLE
  } cac_mode_t;

  // one channel's writable state
  typedef struct packed {
    logic [7:0]  mode;
    logic [15:0] cmp;
    logic [10:0] reload;
  } cac_chan_t;
endpackage

// *** test/cac_pin_model.sv ***
// pin partner: drives the channel inputs and merges the design drive
`timescale 1ns/1ps
module cac_pin_model (
  // clock
  input  wire logic       hclk,
  // requested levels and the design's drive
  input  wire logic [5:0] want,
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe_n,
  // wire level fed back to the design
  output logic      [5:0] pin_in
);
  logic [5:0] lvl = 6'h00;
  logic [5:0] old = 6'h00;
  // a level moves only after it has stood two clocks, so short pulses stall
  always @(posedge hclk) begin
    old <= lvl;
    for (int i = 0; i < 6; i++)
      if (lvl[i] == old[i]) lvl[i] <= want[i];
  end
  // where the design drives, the wire follows the design
  assign pin_in = (pin_oe_n & lvl) | (~pin_oe_n & pin_out);
endmodule

// *** test/cac_checker.sv ***
// port assertions for the capture/compare array
`timescale 1ns/1ps
`include "cac_defs.svh"
module cac_checker (
  // clock, reset and bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // counter, pins and interrupt
  input wire logic        count_tick,
  input wire logic [5:0]  module_io_pin_out,
  input wire logic [5:0]  module_io_pin_oe_n,
  input wire logic        counter_array_irq
);
  logic       take;
  logic       rd_q;
  logic [7:0] adr_q;
  logic [3:0] wr_h;
  logic [1:0] tk_h;
  assign take = hsel && hready && htrans[1];
  // recent bus writes and ticks: the only causes an output may react to
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q  <= 1'b0;
      adr_q <= 8'h00;
      wr_h  <= 4'h0;
      tk_h  <= 2'h0;
    end else begin
      rd_q  <= take && !hwrite;
      adr_q <= haddr;
      wr_h  <= {wr_h[2:0], take && hwrite};
      tk_h  <= {tk_h[0], count_tick};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  no_wait_a: assert property (hreadyout)
    else $error("slave inserted a wait state");
  okay_resp_a: assert property (!hresp)
    else $error("slave answered with an error");
  idle_data_a: assert property (!rd_q |-> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  hole_read_a: assert property (rd_q && adr_q > `CAC_OFF_LAST |-> !hrdata)
    else $error("unmapped word read non-zero");
  narrow_reg_a: assert property
    (rd_q && adr_q != `CAC_OFF_CNT |-> hrdata[31:8] == 24'h0)
    else $error("byte register read wide");
  flag_sticky_a: assert property ($fell(counter_array_irq) |-> |wr_h)
    else $error("interrupt dropped without a write");
  pin_cause_a: assert property
    ($changed(module_io_pin_out) |-> |tk_h || |wr_h)
    else $error("pin moved without counter event or write");
  reset_out_a: assert property ($rose(hresetn) |->
    module_io_pin_oe_n == 6'h3F && !module_io_pin_out && !counter_array_irq)
    else $error("outputs not at reset level");
  irq_seen_c: cover property ($rose(counter_array_irq));
  pin_move_c: cover property ($changed(module_io_pin_out));
  read_c: cover property (rd_q && hrdata != 32'h0);
endmodule

bind cac_array cac_checker u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .count_tick(count_tick), .module_io_pin_out(module_io_pin_out),
  .module_io_pin_oe_n(module_io_pin_oe_n),
  .counter_array_irq(counter_array_irq));

// *** test/cac_array_tb_top.sv ***
// self-checking bench for the capture/compare array
`timescale 1ns/1ps
`include "cac_defs.svh"
module cac_array_tb_top;
  `define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin \
    err_count++; $display("mismatch at %0t: %0h vs %0h", $time, g, e); \
    end end
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic        count_tick;
  logic        slow;
  logic [1:0]  htrans;
  logic [7:0]  haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic [5:0]  want;
  logic [5:0]  pin_i;
  logic [5:0]  pin_o;
  logic [5:0]  pin_oe_n;
  int          err_count;
  int          n_checks;
  int          hi;
  int          tg;
  int          v;
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // counter clock every cycle, or at random while slowed
  always @(posedge hclk) count_tick <= slow ? 1'($urandom % 2) : 1'b1;
  cac_array dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .count_tick(count_tick),
    .module_io_pin_in(pin_i), .module_io_pin_out(pin_o),
    .module_io_pin_oe_n(pin_oe_n), .counter_array_irq(irq));
  cac_pin_model pins (.hclk(hclk), .want(want), .pin_out(pin_o),
    .pin_oe_n(pin_oe_n), .pin_in(pin_i));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // waits for hready; a hung slave ends the run
  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 20) begin
        err_count++;
        end_of_test();
      end
      @(posedge hclk);
    end
  endtask
  // one single word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    htrans <= 2'h2;
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  // cycles high and toggles of one pin over n clocks
  task automatic watch(input int ch, input int n);
    logic last;
    hi = 0;
    tg = 0;
    last = pin_o[ch];
    repeat (n) begin
      @(posedge hclk);
      hi += pin_o[ch];
      tg += (pin_o[ch] != last);
      last = pin_o[ch];
    end
  endtask
  initial begin
    {hresetn, hsel, hwrite, slow, htrans, haddr, hwdata, want} = '0;
    err_count = 0;
    n_checks = 0;
    v = $urandom(32'hDA88);
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    // every word zero after reset, an unmapped word stays zero
    for (int a = 0; a <= 8'h58; a += 4) begin
      bus(1'b0, 8'(a), 32'h0);
      `CHK(rd, 32'h0)
    end
    bus(1'b1, 8'h58, 32'hFF);
    bus(1'b0, 8'h58, 32'h0);
    `CHK(rd, 32'h0)
    $display("test registers done");
    // capture on channel 1 with the counter stopped at a random value
    for (int s = 1; s < 4; s++) begin
      v = $urandom & 32'hFFFF;
      bus(1'b1, `CAC_OFF_CNT, v);
      bus(1'b1, `CAC_OFF_MODE0 + 8'h04, 32'(s << 4));
      for (int e = 0; e < 2; e++) begin
        want[1] <= ~want[1];
        repeat (8) @(posedge hclk);
        bus(1'b0, `CAC_OFF_FLAGS, 32'h0);
        `CHK(rd[1], s[1 - e])
        `CHK(irq, 1'b0)
        if (s[1 - e]) begin
          bus(1'b0, `CAC_OFF_CMPL0 + 8'h04, 32'h0);
          `CHK(rd, v & 32'hFF)
          bus(1'b0, `CAC_OFF_CMPH0 + 8'h04, 32'h0);
          `CHK(rd, v >> 8)
        end
        bus(1'b1, `CAC_OFF_FLAGS, 32'h0);
      end
    end
    $display("test capture done");
    // timer on channel 0: low-byte-only match must not flag
    bus(1'b1, `CAC_OFF_MODE0, 32'h49);
    bus(1'b1, `CAC_OFF_CMPL0, 32'h40);
    bus(1'b0, `CAC_OFF_MODE0, 32'h0);
    `CHK(rd, 32'h09)
    bus(1'b1, `CAC_OFF_CMPH0, 32'h01);
    bus(1'b0, `CAC_OFF_MODE0, 32'h0);
    `CHK(rd, 32'h49)
    bus(1'b1, `CAC_OFF_CNT, 32'h35);
    bus(1'b1, `CAC_OFF_CTRL, 32'h1);
    repeat (20) @(posedge hclk);
    bus(1'b0, `CAC_OFF_FLAGS, 32'h0);
    `CHK(rd, 32'h0)
    slow <= 1'b1;
    bus(1'b1, `CAC_OFF_CNT, 32'h138);
    for (v = 0; v < 200 && irq !== 1'b1; v++) @(posedge hclk);
    if (v == 200) begin
      err_count++;
      end_of_test();
    end
    slow <= 1'b0;
    bus(1'b0, `CAC_OFF_FLAGS, 32'h0);
    `CHK(rd, 32'h01)
    repeat (20) @(posedge hclk);
    `CHK(irq, 1'b1)
    bus(1'b1, `CAC_OFF_FLAGS, 32'h0);
    repeat (4) @(posedge hclk);
    `CHK(irq, 1'b0)
    $display("test timer done");
    // high-speed toggle on channel 2, then comparator off
    bus(1'b1, `CAC_OFF_MODE0 + 8'h08, 32'h4C);
    for (int r = 0; r < 2; r++) begin
      bus(1'b1, `CAC_OFF_CMPL0 + 8'h08, 32'h0);
      if (r == 0) bus(1'b1, `CAC_OFF_CMPH0 + 8'h08, 32'h20);
      bus(1'b1, `CAC_OFF_CNT, 32'h1FF0);
      watch(2, 40);
      `CHK(tg, 1 - r)
    end
    bus(1'b0, `CAC_OFF_FLAGS, 32'h0);
    `CHK(rd[2], 1'b1)
    `CHK(pin_oe_n[2], 1'b0)
    $display("test toggle done");
    // n-bit pwm on channels 3 and 4 for each cycle length
    for (int cl = 0; cl < 4; cl++) begin
      bus(1'b1, `CAC_OFF_PWMCFG, 32'(cl | (cl != 0) << 7));
      for (int c = 3; c < 5; c++) begin
        v = (c * 16 - 32) << cl;
        bus(1'b1, `CAC_OFF_MODE0 + 8'(4 * c), 32'h4A);
        bus(1'b1, `CAC_OFF_CMPL0 + 8'(4 * c), v & 32'hFF);
        bus(1'b1, `CAC_OFF_CMPH0 + 8'(4 * c), cl ? v >> 8 : v);
      end
      bus(1'b1, `CAC_OFF_PWMCFG, 32'(cl));
      repeat (512 << cl) @(posedge hclk);
      bus(1'b1, `CAC_OFF_FLAGS, 32'h0);
      for (int c = 3; c < 5; c++) begin
        watch(c, 256 << cl);
        `CHK(hi, (256 - c * 16 + 32) << cl)
      end
      bus(1'b0, `CAC_OFF_FLAGS, 32'h0);
      `CHK(rd[7], 1'b1)
    end
    bus(1'b1, `CAC_OFF_CMPL0 + 8'h0C, 32'h0);
    @(posedge hclk); // comparator-off reaches the pin one clock later
    watch(3, 2048);
    `CHK(hi, 0)
    $display("test pwm done");
    // frequency output on channel 5, high byte 0x20 then zero
    for (int h = 0; h < 2; h++) begin
      bus(1'b1, `CAC_OFF_MODE0 + 8'h14, 32'h46);
      bus(1'b1, `CAC_OFF_CMPL0 + 8'h14, 32'h0);
      bus(1'b1, `CAC_OFF_CMPH0 + 8'h14, h ? 32'h0 : 32'h20);
      repeat (300) @(posedge hclk);
      watch(5, 1024);
      `CHK(tg, h ? 4 : 32)
    end
    $display("test frequency done");
    // 16-bit pwm on channel 0 across the counter wrap
    bus(1'b1, `CAC_OFF_CNT, 32'hFF00);
    bus(1'b1, `CAC_OFF_FLAGS, 32'h0);
    bus(1'b1, `CAC_OFF_MODE0, 32'hC2);
    bus(1'b1, `CAC_OFF_CMPL0, 32'h80);
    bus(1'b1, `CAC_OFF_CMPH0, 32'hFF);
    watch(0, 300);
    `CHK(hi, 128)
    bus(1'b0, `CAC_OFF_FLAGS, 32'h0);
    `CHK(rd[6], 1'b1)
    $display("test wide pwm done");
    end_of_test();
  end
endmodule
